// [rtl/ctao_defs.vh]
// Notes on behaviour
// - c7 write only: invalidate whole cache
// - c9 sets victim+base (c0) or victim (c1)
// - operand addresses, holding register carries data
// - tag read: segment bits 6:5 into holding
// - tag write stores tag, valid at victim
// - dirty and writeback bits in tag write ignored
// - data read: segment 6:5, word 4:2
// - data write stores holding word there
// - tag match read compares bits 31:7
// - match read: no translation, no refill
// - holding register access: opcode_1 3, c3, 0
// - victim+base mode: advance on tag and data
// - victim-only mode: advance on tag only
// - victim+base index in bits 31:26, both set
// - victim-only: index 31:26, segment 6:5
// - tag read captures current victim pointer
// - test ops only while test enable set
// - direction bit: set write, clear read
`ifndef CTAO_DEFS_VH
`define CTAO_DEFS_VH

// register byte addresses
`define CTAO_ADDR_CMD      4'h0
`define CTAO_ADDR_OPERAND  4'h4
`define CTAO_ADDR_RESULT   4'h8
`define CTAO_ADDR_TEST     4'hC
`define CTAO_ADDR_VICTIM   4'h0
`define CTAO_ADDR_STATUS   4'h4
// the high nibble selects bank 0 (0x00-0x0C) or bank 1 (0x10-0x14)
`define CTAO_BANK_HI       1'b1

// command register fields
`define CTAO_CMD_OPC1      2:0
`define CTAO_CMD_OPC2      6:4
`define CTAO_CMD_CRN       11:8
`define CTAO_CMD_CRM       15:12
`define CTAO_CMD_DIR       16
`define CTAO_CMD_W         17

// coprocessor register numbers and opcodes
`define CTAO_CRN_MAINT     4'h7
`define CTAO_CRN_LOCK      4'h9
`define CTAO_CRN_TEST      4'hF
`define CTAO_CRM_C0        4'h0
`define CTAO_CRM_C1        4'h1
`define CTAO_CRM_C3        4'h3
`define CTAO_CRM_C7        4'h7
`define CTAO_CRM_C11       4'hB
`define CTAO_OPC1_ZERO     3'h0
`define CTAO_OPC1_ARRAY    3'h2
`define CTAO_OPC1_HOLD     3'h3
`define CTAO_OPC2_ZERO     3'h0
`define CTAO_OPC2_ONE      3'h1
`define CTAO_OPC2_READ     3'h2
`define CTAO_OPC2_MATCH    3'h5
`define CTAO_OPC2_WRITE    3'h6

// operand fields
`define CTAO_OP_INDEX      31:26
`define CTAO_OP_TAG        31:7
`define CTAO_OP_SEG        6:5
`define CTAO_OP_VALID      4
`define CTAO_OP_WORD       4:2

// geometry
`define CTAO_SEGS          4
`define CTAO_LINES         64
`define CTAO_ENTRIES       256
`define CTAO_WORDS         2048
`define CTAO_TAG_W         25
`define CTAO_PTR_W         6

// bus answers
`define CTAO_RESP_OKAY     2'h0
`define CTAO_RESP_SLVERR   2'h2

`endif

// [rtl/ctao_cache_test.v]
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ctao_defs.vh"

module ctao_cache_test (
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire [4:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [4:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

    // cache arrays: tags, valid bits and data words
    reg [`CTAO_TAG_W-1:0] tag_mem [0:`CTAO_ENTRIES-1];
    reg [`CTAO_ENTRIES-1:0] valid_bits;
    reg [31:0]            data_mem [0:`CTAO_WORDS-1];

    // software visible state
    reg [31:0]            operand;
    reg [31:0]            hold;            // test holding register
    reg [31:0]            result;
    reg                   test_en;
    reg [`CTAO_PTR_W-1:0] victim [0:`CTAO_SEGS-1];
    reg [`CTAO_PTR_W-1:0] lock_base;
    reg                   base_mode;       // 1 after victim+base, 0 after victim only
    reg                   match_hit;
    reg                   rejected;

    // bus write side
    reg                   aw_held;
    reg                   w_held;
    reg [4:0]             aw_addr;
    reg [31:0]            w_data;
    reg [3:0]             w_strb;
    reg [16:0]            cmd;
    reg                   exec;

    // loop counters: one for the clocked reset and pointer loops,
    // one for the combinational tag search, so that no variable is
    // written from two processes
    integer i;
    integer j;

    // the command register keeps only bits 16:0, the transfer fields and two spare bits; upper bits of a
    // write are dropped so that a stray high byte never aliases a field
    wire [31:0] cmd_merged;

    // byte-lane merge of a write into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_data;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b])
                    merge[b*8 +: 8] = new_data[b*8 +: 8];
            end
        end
    endfunction

    // decodes an aligned register address, bit 4 picks the bank
    function hit_reg;
        input [4:0] addr;
        input       bank;
        input [3:0] off;
        begin
            hit_reg = (addr[4] == bank) && (addr[3:0] == off);
        end
    endfunction

    // merged command word, byte lanes honoured like the operand register
    assign cmd_merged = merge({{(32-`CTAO_CMD_W){1'b0}}, cmd}, w_data, w_strb);

    // operand decode
    // every array access but the match read and the invalidate is indexed by the segment's victim pointer, not by
    // the operand: software must load the pointer first, and a wrong pointer
    // silently hits another line rather than being refused
    wire [1:0]             seg      = operand[`CTAO_OP_SEG];
    wire [2:0]             word     = operand[`CTAO_OP_WORD];
    wire [`CTAO_PTR_W-1:0] vptr     = victim[seg];
    wire [7:0]             line_idx = {seg, vptr};
    wire [10:0]            word_idx = {seg, vptr, word};

    // command decode, L bit set means write transfer
    wire [2:0] opc1   = cmd[`CTAO_CMD_OPC1];
    wire [2:0] opc2   = cmd[`CTAO_CMD_OPC2];
    wire [3:0] crn    = cmd[`CTAO_CMD_CRN];
    wire [3:0] crm    = cmd[`CTAO_CMD_CRM];
    wire       is_wr  = cmd[`CTAO_CMD_DIR];
    wire       arr_op = exec && is_wr && crn == `CTAO_CRN_TEST && opc1 == `CTAO_OPC1_ARRAY;
    wire       do_inv = exec && is_wr && crn == `CTAO_CRN_MAINT && crm == `CTAO_CRM_C7
                        && opc1 == `CTAO_OPC1_ZERO && opc2 == `CTAO_OPC2_ZERO;
    wire       lk_op  = exec && is_wr && crn == `CTAO_CRN_LOCK && opc1 == `CTAO_OPC1_ZERO
                        && (opc2 == `CTAO_OPC2_ZERO || opc2 == `CTAO_OPC2_ONE);
    wire       do_vb  = lk_op && crm == `CTAO_CRM_C0;
    wire       do_vo  = lk_op && crm == `CTAO_CRM_C1;
    // test operations need the enable bit
    wire       do_tr  = test_en && arr_op && crm == `CTAO_CRM_C7 && opc2 == `CTAO_OPC2_READ;
    wire       do_tw  = test_en && arr_op && crm == `CTAO_CRM_C7 && opc2 == `CTAO_OPC2_WRITE;
    wire       do_tm  = test_en && arr_op && crm == `CTAO_CRM_C7 && opc2 == `CTAO_OPC2_MATCH;
    wire       do_dr  = test_en && arr_op && crm == `CTAO_CRM_C11 && opc2 == `CTAO_OPC2_READ;
    wire       do_dw  = test_en && arr_op && crm == `CTAO_CRM_C11 && opc2 == `CTAO_OPC2_WRITE;
    wire       hold_x = test_en && exec && crn == `CTAO_CRN_TEST && opc1 == `CTAO_OPC1_HOLD
                        && crm == `CTAO_CRM_C3 && opc2 == `CTAO_OPC2_ZERO;
    wire       do_hw  = hold_x && is_wr;
    wire       do_hr  = hold_x && !is_wr;
    wire       known  = do_inv || do_vb || do_vo || do_tr || do_tw || do_tm
                        || do_dr || do_dw || do_hw || do_hr;

    // tag search within the segment; no translation and no refill
    // the search is a flat compare over all lines of one segment; it costs
    // area but finishes in one cycle, so a match read never stalls the bus
    // only valid lines may hit: stale tags of invalidated lines are ignored
    // when two lines carry the same tag the lowest line wins, a limitation
    // that software test code must keep in mind when it fills the tags
    reg                   next_hit;
    reg [`CTAO_PTR_W-1:0] next_line;
    always @* begin
        next_hit  = 1'b0;
        next_line = {`CTAO_PTR_W{1'b0}};
        for (j = 0; j < `CTAO_LINES; j = j + 1) begin
            if (!next_hit && valid_bits[{seg, j[5:0]}]
                && tag_mem[{seg, j[5:0]}] == operand[`CTAO_OP_TAG]) begin
                next_hit  = 1'b1;
                next_line = j[5:0];
            end
        end
    end

    // victim advance: tag reads and writes always, data ops only in victim+base mode
    wire adv = do_tr || do_tw || (base_mode && (do_dr || do_dw));

    // bus write channel: address and data taken in either order
    // each ready is a one-cycle pulse; once a channel is held no further
    // beat is taken until the response is raised, so the slave never needs
    // more than one address and one data word of storage
    // the response is raised in the cycle both halves are held, and the
    // register effect lands at the same edge, so a read issued after the
    // response always sees the new value
    wire wr_go = aw_held && w_held && !S_AXI_BVALID;
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `CTAO_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 5'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (hit_reg(aw_addr, 1'b0, `CTAO_ADDR_CMD)
                    || hit_reg(aw_addr, 1'b0, `CTAO_ADDR_OPERAND)
                    || hit_reg(aw_addr, 1'b0, `CTAO_ADDR_TEST))
                    S_AXI_BRESP <= `CTAO_RESP_OKAY;
                else
                    S_AXI_BRESP <= `CTAO_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // register writes; a command write fires one execution cycle
    // the operation runs on the operand as it stands one cycle after the
    // command commits; writing the operand after the command is too late
    // for that command, which keeps the order of writes meaningful
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd     <= 17'h00000;
            operand <= 32'h00000000;
            test_en <= 1'b0;
            exec    <= 1'b0;
        end else begin
            exec <= 1'b0;
            if (wr_go && hit_reg(aw_addr, 1'b0, `CTAO_ADDR_CMD)) begin
                cmd  <= cmd_merged[`CTAO_CMD_W-1:0];
                exec <= 1'b1;
            end
            if (wr_go && hit_reg(aw_addr, 1'b0, `CTAO_ADDR_OPERAND))
                operand <= merge(operand, w_data, w_strb);
            if (wr_go && hit_reg(aw_addr, 1'b0, `CTAO_ADDR_TEST) && w_strb[0])
                test_en <= w_data[0];
        end
    end

    // victim pointers, lockdown base and mode
    // a pointer load takes priority over an advance; both cannot come from
    // one command anyway, since only one operation executes per cycle
    // the mode flag is global: the last pointer load decides whether data
    // accesses advance the pointer, for every segment alike
    // pointers wrap silently at the top index, with no overflow flag
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (i = 0; i < `CTAO_SEGS; i = i + 1)
                victim[i] <= {`CTAO_PTR_W{1'b0}};
            lock_base <= {`CTAO_PTR_W{1'b0}};
            base_mode <= 1'b0;
        end else if (do_vb) begin
            // one index sets the victim of every segment and the single lock base
            for (i = 0; i < `CTAO_SEGS; i = i + 1)
                victim[i] <= operand[`CTAO_OP_INDEX];
            lock_base <= operand[`CTAO_OP_INDEX];
            base_mode <= 1'b1;
        end else if (do_vo) begin
            victim[seg] <= operand[`CTAO_OP_INDEX];
            base_mode   <= 1'b0;
        end else if (adv) begin
            // indexing relies on software having loaded the pointer
            victim[seg] <= vptr + 6'h01;
        end
    end

    // holding register, result and operation status
    // the holding register is the only path out of the arrays and for data words into them;
    // a match miss leaves it untouched; the status hit flag tells a miss from a
    // hit on a word that happens to equal the old contents
    // the refused flag tracks the last executed command only, so software
    // must read the status before issuing the next command
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold      <= 32'h00000000;
            result    <= 32'h00000000;
            match_hit <= 1'b0;
            rejected  <= 1'b0;
        end else begin
            if (do_hw)
                hold <= operand;
            if (do_hr)
                result <= hold;
            if (do_tr)
                // tag, then the victim pointer in use, then valid
                hold <= {tag_mem[line_idx], vptr, valid_bits[line_idx]};
            if (do_dr)
                hold <= data_mem[word_idx];
            if (do_tm) begin
                match_hit <= next_hit;
                if (next_hit)
                    hold <= data_mem[{seg, next_line, word}];
            end
            if (exec)
                rejected <= !known;
        end
    end

    // array updates; only valid and tag taken from a tag write
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            valid_bits <= {`CTAO_ENTRIES{1'b0}};
        end else if (do_inv) begin
            valid_bits <= {`CTAO_ENTRIES{1'b0}};
        end else if (do_tw) begin
            valid_bits[line_idx] <= operand[`CTAO_OP_VALID];
        end
    end

    // arrays carry no reset, as real cache rams would not
    // reading a line that was never written returns unknowns; the valid
    // bits do carry a reset so that a match read after reset cannot hit
    always @(posedge REF_CLK) begin
        if (do_tw)
            tag_mem[line_idx] <= operand[`CTAO_OP_TAG];
        if (do_dw)
            data_mem[word_idx] <= hold;
    end

    // bus read channel
    // the read data is latched at the address handshake and stands until it
    // is taken, so state changing behind it does not tear an answer
    // unmapped addresses answer with an error and zero data, never with
    // stale contents of an earlier read
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `CTAO_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `CTAO_RESP_OKAY;
                if (hit_reg(S_AXI_ARADDR, 1'b0, `CTAO_ADDR_CMD))
                    S_AXI_RDATA <= {15'h0000, cmd};
                else if (hit_reg(S_AXI_ARADDR, 1'b0, `CTAO_ADDR_OPERAND))
                    S_AXI_RDATA <= operand;
                else if (hit_reg(S_AXI_ARADDR, 1'b0, `CTAO_ADDR_RESULT))
                    S_AXI_RDATA <= result;
                else if (hit_reg(S_AXI_ARADDR, 1'b0, `CTAO_ADDR_TEST))
                    S_AXI_RDATA <= {31'h00000000, test_en};
                else if (hit_reg(S_AXI_ARADDR, `CTAO_BANK_HI, `CTAO_ADDR_VICTIM))
                    S_AXI_RDATA <= {8'h00, victim[3], victim[2], victim[1], victim[0]};
                else if (hit_reg(S_AXI_ARADDR, `CTAO_BANK_HI, `CTAO_ADDR_STATUS))
                    S_AXI_RDATA <= {23'h000000, lock_base, base_mode, rejected, match_hit};
                else begin
                    S_AXI_RDATA <= 32'h00000000;
                    S_AXI_RRESP <= `CTAO_RESP_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule // ctao_cache_test

`default_nettype wire

// [verification/ctao_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ctao_chk (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // answers stand untouched until the master takes them
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
    property p_aw_pulse; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("address ready held");
    property p_w_pulse; S_AXI_WREADY |=> !S_AXI_WREADY; endproperty
    a_w_pulse: assert property (p_w_pulse) else $error("data ready held");
    // read data follows the address handshake by one cycle
    property p_r_after_ar; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
    property p_no_ar_in_r; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_no_ar_in_r: assert property (p_no_ar_in_r) else $error("read taken while busy");
    property p_b_bound; S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:16] S_AXI_BVALID; endproperty
    a_b_bound: assert property (p_b_bound) else $error("write answer missing");
    property p_b_drop; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
    property p_err_zero; S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read carries data");
endmodule // ctao_chk
`default_nettype wire

// [verification/ctao_axi_master.sv]
`timescale 1ns/1ps
`default_nettype none
module ctao_axi_master (
    input  wire logic        clk,
    output var  logic [4:0]  awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic [3:0]  wstrb,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output var  logic        bready,
    output var  logic [4:0]  araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic        rvalid,
    output var  logic        rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // released payloads show the inverse so stale values never pass
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
        fork
            begin do @(posedge clk); while (!awready); awvalid <= 1'b0; awaddr <= ~a; end
            begin do @(posedge clk); while (!wready); wvalid <= 1'b0; wdata <= ~d; wstrb <= ~s; end
            begin do @(posedge clk); while (!bvalid); bready <= 1'b0; end
        join
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0; araddr <= ~a;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask
endmodule // ctao_axi_master
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [4:0] CMD = 5'h00, OP = 5'h04, RES = 5'h08, TST = 5'h0C;
    localparam logic [4:0] VIC = 5'h10, STA = 5'h14, BAD = 5'h18;
    logic REF_CLK = 1'b0, RST_N = 1'b0;
    wire logic [4:0] awaddr, araddr;
    wire logic [31:0] wdata, rdata;
    wire logic [3:0] wstrb;
    wire logic [1:0] bresp, rresp;
    wire logic awv, awr, wv, wr_, bv, br, arv, arr_, rv, rr;
    logic [65:0] exp_r[$];
    logic [1:0] exp_b[$];
    int checks = 0, n_mismatch = 0;
    logic [31:0] d, t;
    always #10 REF_CLK = ~REF_CLK;
    ctao_cache_test dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr_),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    ctao_axi_master m (.clk(REF_CLK), .awaddr(awaddr), .awvalid(awv), .awready(awr),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wv), .wready(wr_), .bvalid(bv), .bready(br),
        .araddr(araddr), .arvalid(arv), .arready(arr_), .rvalid(rv), .rready(rr));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // command word: direction, CRm, CRn, opcode_2, opcode_1
    function automatic logic [31:0] mk(input logic dr, input logic [3:0] n, input logic [3:0] cm,
                                       input logic [2:0] o1, input logic [2:0] o2);
        return {15'h0, dr, cm, n, 1'b0, o2, 1'b0, o1};
    endfunction
    task automatic w(input logic [4:0] a, input logic [31:0] v);
        exp_b.push_back(2'h0);
        m.wr(a, v, 4'hF);
    endtask
    task automatic r(input logic [4:0] a, input logic [31:0] e, input logic [31:0] k,
                     input logic [1:0] rs);
        exp_r.push_back({rs, k, e});
        m.rd(a);
    endtask
    task automatic op(input logic [31:0] v, input logic [31:0] c);
        w(OP, v);
        w(CMD, c);
    endtask
    task automatic arr(input logic [3:0] cm, input logic [2:0] o2, input logic [31:0] v);
        op(v, mk(1'b1, 4'hF, cm, 3'h2, o2));
    endtask
    task automatic hw(input logic [31:0] v);
        op(v, mk(1'b1, 4'hF, 4'h3, 3'h3, 3'h0));
    endtask
    task automatic hr(input logic [31:0] e);
        op(32'h0, mk(1'b0, 4'hF, 4'h3, 3'h3, 3'h0));
        r(RES, e, 32'hFFFFFFFF, 2'h0);
    endtask
    // base form fills the ignored low bits with junk on purpose
    task automatic vic(input logic [5:0] i, input logic [1:0] sg, input logic b, input logic [2:0] o2);
        op(b ? {i, 26'h3FFFF55} : {i, 19'h0, sg, 5'h0}, mk(1'b1, 4'h9, {3'h0, ~b}, 3'h0, o2));
    endtask
    // compares each answer against the oldest note
    always @(posedge REF_CLK) begin
        logic [65:0] e;
        if (rv && rr) begin
            e = exp_r.pop_front();
            chk("rdata", rdata & e[63:32], e[31:0]);
            chk("rresp", {30'h0, rresp}, {30'h0, e[65:64]});
        end
        if (bv && br) chk("bresp", {30'h0, bresp}, {30'h0, exp_b.pop_front()});
    end
    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(96));
        repeat (4) @(posedge REF_CLK);
        RST_N <= 1'b1;
        r(TST, 32'h0, 32'hFFFFFFFF, 2'h0);
        r(VIC, 32'h0, 32'hFFFFFFFF, 2'h0);
        r(BAD, 32'h0, 32'hFFFFFFFF, 2'h2);
        exp_b.push_back(2'h2);
        m.wr(BAD, 32'h1, 4'hF);
        d = $urandom;
        t = $urandom;
        hw(d);
        hr(32'h0);
        r(STA, 32'h2, 32'h2, 2'h0);
        w(TST, 32'h1);
        w(OP, d);
        exp_b.push_back(2'h0);
        m.wr(OP, 32'h5A, 4'h1);
        r(OP, {d[31:8], 8'h5A}, 32'hFFFFFFFF, 2'h0);
        hw(d);
        hr(d);
        op(32'h0, mk(1'b1, 4'h7, 4'h7, 3'h0, 3'h0));
        vic(6'd63, 2'd2, 1'b0, 3'h0);
        r(VIC, 32'd63 << 12, 32'hFFFFFFFF, 2'h0);
        arr(4'h7, 3'h6, {t[31:7], 2'd2, 5'h1F});
        r(VIC, 32'h0, 32'hFFFFFFFF, 2'h0);
        vic(6'd63, 2'd2, 1'b0, 3'h1);
        arr(4'h7, 3'h2, {~t[31:7], 2'd2, 5'h1F});
        hr({t[31:7], 6'd63, 1'b1});
        vic(6'd5, 2'd0, 1'b1, 3'h0);
        r(VIC, {8'h0, {4{6'd5}}}, 32'hFFFFFFFF, 2'h0);
        r(STA, 32'h2C, 32'h1FC, 2'h0);
        d = $urandom;
        hw(d);
        arr(4'hB, 3'h6, {25'h0, 2'd1, 3'd3, 2'd0});
        r(VIC, {8'h0, 6'd5, 6'd5, 6'd6, 6'd5}, 32'hFFFFFFFF, 2'h0);
        vic(6'd5, 2'd0, 1'b1, 3'h1);
        arr(4'hB, 3'h2, {25'h0, 2'd1, 3'd3, 2'd3});
        hr(d);
        vic(6'd9, 2'd0, 1'b0, 3'h0);
        arr(4'hB, 3'h2, {25'h0, 2'd0, 3'd0, 2'd0});
        r(VIC, {8'h0, 6'd5, 6'd5, 6'd6, 6'd9}, 32'hFFFFFFFF, 2'h0);
        vic(6'd7, 2'd0, 1'b1, 3'h0);
        arr(4'h7, 3'h6, {t[31:7], 2'd3, 5'h10});
        vic(6'd7, 2'd0, 1'b1, 3'h0);
        d = $urandom;
        hw(d);
        arr(4'hB, 3'h6, {25'h0, 2'd3, 3'd5, 2'd0});
        hw(32'h0);
        arr(4'h7, 3'h5, {t[31:7], 2'd3, 3'd5, 2'd0});
        hr(d);
        r(STA, 32'h1, 32'h1, 2'h0);
        op(32'h0, mk(1'b1, 4'h7, 4'h7, 3'h0, 3'h0));
        hw(32'h0);
        arr(4'h7, 3'h5, {t[31:7], 2'd3, 3'd5, 2'd0});
        hr(32'h0);
        r(STA, 32'h0, 32'h1, 2'h0);
        repeat (4) @(posedge REF_CLK);
        final_report();
    end
endmodule // tb
bind ctao_cache_test ctao_chk u_chk (.REF_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
`default_nettype wire
